// ===== core/bmsc_pkg.sv
package bmsc_pkg;

  // Clock rate and servo divider.
  localparam int unsigned CLK_HZ       = 50000000;
  localparam int unsigned SERVO_DIV    = 8192;
  // Lock window is 1/16 of the target period (6.25 percent).
  localparam int unsigned LOCK_SHIFT   = 4;
  // Carrier frequency and derived cycles per carrier period.
  localparam int unsigned PWM_HZ       = 15000;
  localparam int unsigned PWM_CYC      = CLK_HZ / PWM_HZ;
  // A charge-pump correction pulse lasts this many clock cycles plus one.
  localparam int unsigned PUMP_CYC     = 64;
  // Duty step applied per correction and the reset duty.
  localparam logic [11:0] DUTY_STEP    = 12'h010;
  localparam logic [11:0] DUTY_RST     = 12'h000;
  // Register map, byte addresses.
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_STAT    = 4'h4;
  localparam logic [3:0]  ADDR_IRQ     = 4'h8;
  localparam logic [3:0]  ADDR_MASK    = 4'hc;
  // Control field positions.
  localparam int unsigned CTRL_STOP    = 0;
  localparam int unsigned CTRL_REV     = 1;
  localparam logic [1:0]  CTRL_RST     = 2'h1;
  // Interrupt bits: lock gained, lock lost, current limit.
  localparam int unsigned IRQ_LOCK     = 0;
  localparam int unsigned IRQ_UNLOCK   = 1;
  localparam int unsigned IRQ_ILIM     = 2;

endpackage

// ===== core/bmsc_pwm_if.sv
`timescale 1ns/100ps
// Carries the carrier and duty between the controller and the PWM generator.
interface bmsc_pwm_if;
  logic [11:0] duty;
  logic        pwm_on;
  logic        period_tick;
  modport ctl (output duty, input pwm_on, input period_tick);
  modport gen (input duty, output pwm_on, output period_tick);
endinterface

// ===== core/bmsc_pwm.sv
`timescale 1ns/100ps
// Carrier counter and duty comparator for the low-side switches.
module bmsc_pwm
  import bmsc_pkg::*;
(
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Link to controller.
  bmsc_pwm_if.gen   pw
);
  logic [11:0] cnt_r;

  // Carrier counter wraps once per PWM period.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 12'h000;
    end else if (cnt_r == 12'(PWM_CYC - 1)) begin
      cnt_r <= 12'h000;
    end else begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  // Duty is compared against the scaled carrier phase.
  assign pw.pwm_on      = (pw.duty > 12'((cnt_r * 24'd4095) / PWM_CYC));
  assign pw.period_tick = (cnt_r == 12'h000);
endmodule

// ===== core/bmsc_core.sv
`timescale 1ns/100ps
// Digital speed servo, commutation and low-side PWM for a 3-phase motor.
module bmsc_core
  import bmsc_pkg::*;
#(
  parameter int unsigned DIV = SERVO_DIV
)(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Host pins.
  input  wire logic        dir_rev,
  input  wire logic        run_stop,
  // Motor side.
  input  wire logic [2:0]  hall_in,
  input  wire logic        tachometer_feedback,
  input  wire logic        cur_limit,
  output logic      [2:0]  src_on,
  output logic      [2:0]  snk_on,
  // Open-collector outputs, enable low means pulled low.
  output logic             speed_lock_flag_oe_n,
  output logic             tach_pulse_monitor_oe_n,
  // Servo outputs.
  output logic             disc_out,
  output logic             phase_error_out,
  output logic             supply_en,
  output logic             irq
);
  localparam int unsigned PW = $clog2(DIV) + 2;

  bmsc_pwm_if pw();
  bmsc_pwm u_pwm (.ref_clk(ref_clk), .sys_rst(sys_rst), .pw(pw));

  logic [1:0]  ctrl_r;
  logic [2:0]  irq_st_r;
  logic [2:0]  irq_mask_r;
  logic [2:0]  tach_sync_r;
  logic [PW-1:0] per_cnt_r;
  logic [PW-1:0] ref_cnt_r;
  logic [PW-1:0] meas_r;
  logic        half_r;
  logic        locked_r;
  logic [11:0] duty_r;
  logic [6:0]  ppump_r;
  logic        stopped;
  logic        tach_rise;
  logic        in_lock;
  logic        over;
  logic [2:0]  ev;

  // Stop is the pin or the software stop bit; reverse likewise.
  assign stopped = run_stop | ctrl_r[CTRL_STOP];

  // Absolute difference helper used by the lock window logic.
  function automatic logic [PW-1:0] absdiff(input logic [PW-1:0] a,
                                            input logic [PW-1:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // Register-bus slave: one-cycle wait, then answer.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data, latched while the answer forms.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      if (avs_address == ADDR_CTRL) begin
        avs_readdata <= {30'h0, ctrl_r};
      end else if (avs_address == ADDR_STAT) begin
        avs_readdata <= {4'h0, duty_r, 13'h0, stopped,
                         disc_out, locked_r};
      end else if (avs_address == ADDR_IRQ) begin
        avs_readdata <= {29'h0, irq_st_r};
      end else if (avs_address == ADDR_MASK) begin
        avs_readdata <= {29'h0, irq_mask_r};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Control and mask writes, taken on the accepting edge.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r     <= CTRL_RST;
      irq_mask_r <= 3'h0;
    end else if (avs_write & ~avs_waitrequest) begin
      if (avs_address == ADDR_CTRL) begin
        // Direction bit only moves while stopped.
        ctrl_r[CTRL_STOP] <= avs_writedata[CTRL_STOP];
        if (stopped) begin
          ctrl_r[CTRL_REV] <= avs_writedata[CTRL_REV];
        end
      end else if (avs_address == ADDR_MASK) begin
        irq_mask_r <= avs_writedata[2:0];
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear.
  assign ev = {cur_limit & ~stopped, tach_rise & locked_r & ~in_lock,
               tach_rise & ~locked_r & in_lock & ~stopped};
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_st_r <= 3'h0;
    end else if (avs_write & ~avs_waitrequest &
                 (avs_address == ADDR_IRQ)) begin
      irq_st_r <= (irq_st_r & ~avs_writedata[2:0]) | ev;
    end else begin
      irq_st_r <= irq_st_r | ev;
    end
  end

  // Level interrupt from unmasked status.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_r & irq_mask_r);
    end
  end

  // Tach synchroniser; the first stage feeds only the second.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tach_sync_r <= 3'h0;
    end else begin
      tach_sync_r <= {tach_sync_r[1:0], tachometer_feedback};
    end
  end
  assign tach_rise = tach_sync_r[1] & ~tach_sync_r[2];

  // Speed monitor mirrors the squared tach signal.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tach_pulse_monitor_oe_n <= 1'b1;
    end else begin
      tach_pulse_monitor_oe_n <= tach_sync_r[1];
    end
  end

  // Measure the tach period in clock cycles, saturating.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt_r <= '0;
      meas_r    <= '1;
    end else if (stopped) begin
      per_cnt_r <= '0;
      meas_r    <= '1;
    end else if (tach_rise) begin
      meas_r    <= per_cnt_r;
      per_cnt_r <= PW'(1); // The edge cycle belongs to the new period.
    end else if (per_cnt_r != '1) begin
      per_cnt_r <= per_cnt_r + 1'b1;
    end
  end

  // Reference divider sets the target tach period.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt_r <= '0;
    end else if (stopped | (ref_cnt_r == PW'(DIV - 1))) begin
      ref_cnt_r <= '0;
    end else begin
      ref_cnt_r <= ref_cnt_r + 1'b1;
    end
  end

  // Lock window is target period plus or minus one sixteenth.
  assign in_lock = absdiff(meas_r, PW'(DIV)) <= PW'(DIV >> LOCK_SHIFT);
  assign over    = meas_r < PW'(DIV); // Short period means fast motor.

  // Lock flag, cleared by reset and by stop.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      locked_r <= 1'b0;
    end else if (stopped) begin
      locked_r <= 1'b0;
    end else if (tach_rise) begin
      locked_r <= in_lock;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed_lock_flag_oe_n <= 1'b1;
    end else begin
      speed_lock_flag_oe_n <= ~locked_r;
    end
  end

  // Every second tach edge the discriminator fires and holds polarity.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_r   <= 1'b0;
      disc_out <= 1'b0;
    end else if (stopped) begin
      half_r   <= 1'b0;
      disc_out <= 1'b0;
    end else if (tach_rise) begin
      half_r <= ~half_r;
      if (half_r) begin
        disc_out <= over;
      end
    end
  end

  // Phase comparator: pulse each tach edge when reference leads.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ppump_r         <= 7'h00;
      phase_error_out <= 1'b0;
    end else if (stopped) begin
      ppump_r         <= 7'h00;
      phase_error_out <= 1'b0;
    end else if (tach_rise) begin
      ppump_r         <= 7'(PUMP_CYC);
      phase_error_out <= ref_cnt_r < PW'(DIV >> 1);
    end else if (ppump_r != 7'h00) begin
      ppump_r <= ppump_r - 7'h01;
    end else begin
      phase_error_out <= 1'b0;
    end
  end

  // Duty integrator: steps on each correction, cut by current limit.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      duty_r <= DUTY_RST;
    end else if (stopped) begin
      duty_r <= DUTY_RST;
    end else if (cur_limit) begin
      duty_r <= (duty_r > DUTY_STEP) ? duty_r - DUTY_STEP : 12'h000;
    end else if (tach_rise & half_r & ~in_lock) begin
      if (over) begin
        duty_r <= (duty_r > DUTY_STEP) ? duty_r - DUTY_STEP : 12'h000;
      end else if (duty_r < 12'hfff - DUTY_STEP) begin
        duty_r <= duty_r + DUTY_STEP;
      end
    end else if (~in_lock & (meas_r == '1) & pw.period_tick &
                 (duty_r < 12'hfff - DUTY_STEP)) begin
      duty_r <= duty_r + DUTY_STEP; // Start-up push with no tach yet.
    end
  end
  assign pw.duty = duty_r;

  // Commutation: six steps, reverse inverts hall polarity.
  logic [2:0] h;
  logic [2:0] src_nxt;
  logic [2:0] snk_nxt;
  always_comb begin
    h = (ctrl_r[CTRL_REV] | dir_rev) ? ~hall_in : hall_in;
    case (h)
      3'b110: begin
        src_nxt = 3'b100;
        snk_nxt = 3'b010;
      end
      3'b100: begin
        src_nxt = 3'b100;
        snk_nxt = 3'b001;
      end
      3'b101: begin
        src_nxt = 3'b010;
        snk_nxt = 3'b001;
      end
      3'b001: begin
        src_nxt = 3'b010;
        snk_nxt = 3'b100;
      end
      3'b011: begin
        src_nxt = 3'b001;
        snk_nxt = 3'b100;
      end
      3'b010: begin
        src_nxt = 3'b001;
        snk_nxt = 3'b010;
      end
      default: begin
        src_nxt = 3'b000;
        snk_nxt = 3'b000;
      end
    endcase
  end

  // Drive stage: low side chopped by PWM, all off when stopped.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_on    <= 3'h0;
      snk_on    <= 3'h0;
      supply_en <= 1'b0;
    end else begin
      supply_en <= ~stopped;
      src_on    <= stopped ? 3'h0 : src_nxt;
      snk_on    <= (stopped | ~pw.pwm_on) ? 3'h0 : snk_nxt;
    end
  end
endmodule

// ===== verif/bmsc_sva.sv
`timescale 1ns/100ps
// Pin-level timing checks for the speed servo core.
module bmsc_sva
  import bmsc_pkg::*;
#(
  parameter int unsigned DIV = SERVO_DIV
)(
  // Clock and reset.
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  // Register bus.
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // Host pins and sensors.
  input wire logic       dir_rev,
  input wire logic       run_stop,
  input wire logic [2:0] hall_in,
  input wire logic       tachometer_feedback,
  // Drive and servo outputs.
  input wire logic [2:0] src_on,
  input wire logic [2:0] snk_on,
  input wire logic       speed_lock_flag_oe_n,
  input wire logic       tach_pulse_monitor_oe_n,
  input wire logic       disc_out,
  input wire logic       phase_error_out
);
  logic [2:0] rst_cnt_r;
  logic       tach_q_r;
  logic [7:0] age_r;
  // Counts cycles since reset and since the last raw tach rise.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_r <= 3'h0;
      tach_q_r <= 1'b0;
      age_r <= 8'hff;
    end else begin
      rst_cnt_r <= (rst_cnt_r == 3'h7) ? 3'h7 : rst_cnt_r + 3'h1;
      tach_q_r <= tachometer_feedback;
      if (tachometer_feedback && !tach_q_r) age_r <= 8'h00;
      else if (age_r != 8'hff) age_r <= age_r + 8'h01;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_stop_drive_off: assert property (
    run_stop [*6] |-> src_on == 3'h0 && snk_on == 3'h0)
    else $error("Drive on while stopped.");
  a_stop_lock_off: assert property (
    run_stop [*6] |-> speed_lock_flag_oe_n)
    else $error("Lock shown while stopped.");
  a_reset_no_lock: assert property (
    rst_cnt_r != 3'h7 |-> speed_lock_flag_oe_n)
    else $error("Lock shown just after reset.");
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus answer late.");
  a_phase_disjoint: assert property (
    (src_on & snk_on) == 3'h0 && $onehot0(src_on) && $onehot0(snk_on))
    else $error("Bad output pair.");
  a_src_steady: assert property (
    ($stable({hall_in, dir_rev, run_stop}) && !avs_write) [*5]
    |-> $stable(src_on))
    else $error("Source switched without cause.");
  a_tach_monitor: assert property (
    rst_cnt_r == 3'h7 |->
    tach_pulse_monitor_oe_n == $past(tachometer_feedback, 3))
    else $error("Speed monitor does not follow tach.");
  a_disc_on_tach: assert property (
    $changed(disc_out) |-> age_r <= 8'h08)
    else $error("Discriminator moved away from tach rise.");
  a_pump_timing: assert property (
    $rose(phase_error_out) |-> age_r <= 8'h48)
    else $error("Phase pulse away from tach rise.");
endmodule
bind bmsc_core bmsc_sva #(.DIV(DIV)) chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .dir_rev(dir_rev), .run_stop(run_stop), .hall_in(hall_in),
  .tachometer_feedback(tachometer_feedback), .src_on(src_on),
  .snk_on(snk_on), .speed_lock_flag_oe_n(speed_lock_flag_oe_n),
  .tach_pulse_monitor_oe_n(tach_pulse_monitor_oe_n),
  .disc_out(disc_out), .phase_error_out(phase_error_out));

// ===== verif/bmsc_motor_model.sv
`timescale 1ns/100ps
// Behavioural rotor: tach and hall sensors that move only while spinning.
module bmsc_motor_model (
  // Clock.
  input  wire logic        ref_clk,
  // Bench control.
  input  wire logic        spin,
  input  wire logic        rev,
  input  wire logic [31:0] half_cyc,
  // Sensor outputs.
  output logic             tach,
  output logic      [2:0]  hall
);
  // Hall word carries the first sensor in its top bit, as the core decodes.
  logic [2:0]  fwd_h [6] = '{3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h2};
  int unsigned cnt = 0;
  int unsigned step = 0;
  initial tach = 1'b0;
  // Tach toggles each half period and stands still when stopped.
  always @(posedge ref_clk) begin
    if (spin) begin
      cnt <= (cnt + 1 >= half_cyc) ? 0 : cnt + 1;
      if (cnt + 1 >= half_cyc) begin
        tach <= !tach;
        step <= (step + 1) % 6;
      end
    end
  end
  // Reverse rotation sees every hall level inverted.
  assign hall = rev ? ~fwd_h[step] : fwd_h[step];
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the motor speed servo core.
module tb_top;
  import bmsc_pkg::*;
  localparam int unsigned DIVS = 256;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd, duty_a, v;
  logic        avs_waitrequest, tach, lock_n, mon_n, disc, pump, sup, irq;
  logic        dir_rev = 1'b0;
  logic        run_stop = 1'b1;
  logic        cur_limit = 1'b0;
  logic        spin = 1'b0;
  logic        lk, plk, dsc;
  logic [2:0]  hall_in, src_on, snk_on;
  int unsigned half_cyc = DIVS / 2;
  int          n_errors = 0, checks_done = 0, cycles = 0, seed = 70, ei;
  int unsigned per_q[$] = '{256, 272, 276, 240, 236};
  logic [2:0]  fwd_h [6] = '{3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h2};
  logic [2:0]  src_t [6] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
  logic [2:0]  snk_t [6] = '{3'h2, 3'h1, 3'h1, 3'h4, 3'h4, 3'h2};
  bmsc_core #(.DIV(DIVS)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dir_rev(dir_rev), .run_stop(run_stop), .hall_in(hall_in),
    .tachometer_feedback(tach), .cur_limit(cur_limit), .src_on(src_on),
    .snk_on(snk_on), .speed_lock_flag_oe_n(lock_n),
    .tach_pulse_monitor_oe_n(mon_n), .disc_out(disc),
    .phase_error_out(pump), .supply_en(sup), .irq(irq));
  bmsc_motor_model mot_u (.ref_clk(ref_clk), .spin(spin), .rev(dir_rev),
    .half_cyc(half_cyc), .tach(tach), .hall(hall_in));
  // Clock and run-length guard.
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One bus cycle held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    // Only the bench-wide cycle limit ends a wait for the answer.
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask
  // Checks the output pair at each hall step for the current direction.
  task automatic walk();
    for (int i = 0; i < 12; i++) begin
      @(hall_in);
      cyc(6);
      chk(mon_n, tach);
      if (!tach) chk(pump, 1'b0);
      for (int k = 0; k < 6; k++) begin
        if ((dir_rev ? ~fwd_h[k] : fwd_h[k]) == hall_in) begin
          chk(src_on, src_t[k]);
          chk(snk_on & ~snk_t[k], 3'h0);
        end
      end
    end
  endtask
  initial begin
    cyc(4);
    sys_rst <= 1'b0;
    cyc(2);
    chk({lock_n, src_on, snk_on, sup}, 8'h80);
    bus_rd(ADDR_CTRL, 32'h1);
    bus_rd(ADDR_STAT, 32'h4);
    bus_rd(4'h2, 32'h0);
    v = $random(seed);
    bus(1'b1, ADDR_MASK, v, rd);
    bus_rd(ADDR_MASK, v & 32'h7);
    bus(1'b1, ADDR_MASK, 32'h7, rd);
    run_stop <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h0, rd);
    spin <= 1'b1;
    cyc(8);
    chk(sup, 1'b1);
    plk = 1'b0;
    foreach (per_q[i]) begin
      bus(1'b1, ADDR_IRQ, 32'h7, rd);
      half_cyc <= per_q[i] / 2;
      cyc(per_q[i] * 5);
      bus(1'b0, ADDR_STAT, 32'h0, duty_a);
      cyc(per_q[i] * 5);
      lk = per_q[i] >= DIVS - DIVS / 16 && per_q[i] <= DIVS + DIVS / 16;
      dsc = per_q[i] < DIVS;
      ei = (lk == plk) ? 0 : (lk ? 1 : 2);
      plk = lk;
      chk({lock_n, disc}, {!lk, dsc});
      bus(1'b0, ADDR_STAT, 32'h0, rd);
      chk(rd[2:0], {1'b0, dsc, lk});
      if (!lk) chk(rd[27:16] > duty_a[27:16], !dsc);
      bus_rd(ADDR_IRQ, ei);
      chk(irq, ei != 0);
    end
    half_cyc <= DIVS / 2;
    cyc(DIVS * 8);
    bus(1'b1, ADDR_IRQ, 32'h7, rd);
    cur_limit <= 1'b1;
    // Long enough for any duty to be stepped down to zero.
    cyc(300);
    chk(snk_on, 3'h0);
    cur_limit <= 1'b0;
    bus_rd(ADDR_IRQ, 32'h4);
    chk(irq, 1'b1);
    bus(1'b1, ADDR_MASK, 32'h0, rd);
    cyc(2);
    chk(irq, 1'b0);
    bus(1'b1, ADDR_MASK, 32'h7, rd);
    bus(1'b1, ADDR_IRQ, 32'h4, rd);
    cyc(2);
    chk(irq, 1'b0);
    walk();
    run_stop <= 1'b1;
    spin <= 1'b0;
    cyc(8);
    chk({src_on, snk_on, lock_n, sup}, 8'h02);
    dir_rev <= 1'b1;
    cyc(2);
    run_stop <= 1'b0;
    spin <= 1'b1;
    walk();
    give_verdict();
  end
endmodule
